// file: pkg/sysctl_params.svh
// Constants for the system reset and configuration register bank
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH
`define SEL_CAUSE 2'h0
`define SEL_FORCE 2'h1
`define SEL_OPTIONS 2'h2
`define SEL_CLKOUT 2'h3
`define BIT_POWER_ON 7
`define BIT_PIN 6
`define BIT_WATCHDOG 5
`define BIT_ILLEGAL 4
`define BIT_CLOCK_GEN 2
`define BIT_LOW_VOLT 1
`define BIT_FORCE 0
`define OPT_WD_ENABLE 7
`define OPT_WD_PERIOD 6
`define OPT_STOP_ENABLE 5
`define OPT_RESET 8'hc0
`define OPT_MASK 8'he3
`define CLK_ENABLE 4
`define CLK_DIV_HI 2
`define CLK_MASK 8'h17
`define WD_SHORT_LOG2 13
`define WD_LONG_LOG2 18
`endif

// file: pkg/sysctl_pkg.sv
// Types for the system reset and configuration register bank
package sysctl_pkg;
    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_reset = 2'b01
    } reset_state_t;
endpackage : sysctl_pkg

// file: core/clock_out_divider.sv
// Divided bus clock generator for the shared port pin
`timescale 1ns/1ps
`default_nettype none
module clock_out_divider #(
    parameter int DIV_W = 3
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_enable,
    input wire logic [DIV_W-1:0] i_divide,
    output logic o_level
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic level;
    logic next_level;

    // Toggle every divide cycles, so period is twice the field
    always_comb begin
        next_count = count;
        next_level = level;
        if (!i_enable || i_divide == '0) begin
            next_count = '0;
            next_level = 1'b0;
        end else if (count + 1'b1 >= i_divide) begin
            next_count = '0;
            next_level = ~level;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            count <= '0;
            level <= 1'b0;
        end else begin
            count <= next_count;
            level <= next_level;
        end
    end

    assign o_level = level;
endmodule : clock_out_divider
`default_nettype wire

// file: core/system_reset_config_regs.sv
// System reset cause, debug force reset, options and clock output registers
`timescale 1ns/1ps
`default_nettype none
`include "sysctl_params.svh"
module system_reset_config_regs (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_power_on_req,
    input wire logic i_low_volt_trip,
    input wire logic i_pin_reset_req,
    input wire logic i_watchdog_timeout,
    input wire logic i_illegal_opcode,
    input wire logic i_stop_exec,
    input wire logic i_background_exec,
    input wire logic i_background_mode_enable,
    input wire logic i_clock_gen_req,
    input wire logic i_low_voltage_reset_enable,
    input wire logic i_low_voltage_stop_enable,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_debug_access,
    input wire logic [1:0] i_sel,
    input wire logic [7:0] i_wdata,
    input wire logic i_port_dir,
    input wire logic i_port_data,
    output logic [7:0] o_rdata,
    output logic o_reset_req,
    output logic o_watchdog_restart,
    output logic o_watchdog_enable,
    output logic o_watchdog_period_select,
    output logic o_stop_mode_enable,
    output logic [4:0] o_watchdog_log2_period,
    output logic o_shared_port_pin_out,
    output logic o_shared_port_pin_oen
);
    sysctl_pkg::reset_state_t state;
    sysctl_pkg::reset_state_t next_state;
    logic [7:0] cause;
    logic [7:0] next_cause;
    logic [7:0] options;
    logic [7:0] next_options;
    logic options_written;
    logic next_options_written;
    logic [7:0] clk_ctrl;
    logic [7:0] next_clk_ctrl;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic force_req;
    logic next_force_req;
    logic wd_src;
    logic ill_src;
    logic lv_src;
    logic clk_level;

    // Sources that actually produce a reset
    always_comb begin
        wd_src = i_watchdog_timeout && options[`OPT_WD_ENABLE];
        ill_src = i_illegal_opcode || (i_stop_exec && !options[`OPT_STOP_ENABLE])
            || (i_background_exec && !i_background_mode_enable);
        lv_src = i_low_volt_trip && i_low_voltage_reset_enable && i_low_voltage_stop_enable;
    end

    // Reset request combines every source plus the debug force
    assign o_reset_req = force_req || wd_src || ill_src || lv_src || i_clock_gen_req
        || i_pin_reset_req || i_power_on_req;

    assign o_watchdog_restart = i_wr && (i_sel == `SEL_CAUSE);

    // Cause capture; flags only move in st_run on a cycle a reset is requested, so a held request recaptures every second cycle
    always_comb begin
        next_state = state;
        next_force_req = 1'b0;
        case (state)
            sysctl_pkg::st_run: begin
                if (o_reset_req) begin
                    next_state = sysctl_pkg::st_reset;
                end
            end
            sysctl_pkg::st_reset: begin
                next_state = sysctl_pkg::st_run;
            end
            default: next_state = sysctl_pkg::st_run;
        endcase
        // one in bit zero forces reset
        if (i_wr && i_debug_access && i_sel == `SEL_FORCE && i_wdata[`BIT_FORCE]) begin
            next_force_req = 1'b1;
        end
    end

    // Flag values for the reset just taken, held through the reset
    logic [7:0] reset_flags;
    always_comb begin
        reset_flags = 8'h00;
        if (i_power_on_req) begin
            reset_flags[`BIT_POWER_ON] = 1'b1;
            reset_flags[`BIT_LOW_VOLT] = 1'b1;
        end else if (lv_src) begin
            reset_flags[`BIT_POWER_ON] = cause[`BIT_POWER_ON];
            reset_flags[`BIT_LOW_VOLT] = 1'b1;
        end else if (!force_req) begin
            reset_flags[`BIT_PIN] = i_pin_reset_req;
            reset_flags[`BIT_WATCHDOG] = wd_src;
            reset_flags[`BIT_ILLEGAL] = ill_src;
            reset_flags[`BIT_CLOCK_GEN] = i_clock_gen_req;
        end
    end

    // Registered state; system reset restores defaults but not cause
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state <= sysctl_pkg::st_run;
            force_req <= 1'b0;
            options <= `OPT_RESET;
            options_written <= 1'b0;
            clk_ctrl <= 8'h00;
            rdata <= 8'h00;
        end else begin
            state <= next_state;
            force_req <= next_force_req;
            options <= next_options;
            options_written <= next_options_written;
            clk_ctrl <= next_clk_ctrl;
            rdata <= next_rdata;
        end
    end

    // Cause flags keep their value across the system reset itself
    // software write never alters
    always_ff @(posedge i_clk) begin
        cause <= next_cause;
    end

    always_comb begin
        next_cause = (state == sysctl_pkg::st_run && o_reset_req) ? reset_flags : cause;
    end

    // Options and clock control writes
    always_comb begin
        next_options = options;
        next_options_written = options_written;
        next_clk_ctrl = clk_ctrl;
        if (o_reset_req) begin
            // New reset re-arms the write-once options
            next_options = `OPT_RESET;
            next_options_written = 1'b0;
            next_clk_ctrl = 8'h00;
        end else if (i_wr && i_sel == `SEL_OPTIONS && !options_written) begin
            next_options = i_wdata & `OPT_MASK;
            next_options_written = 1'b1;
        end else if (i_wr && i_sel == `SEL_CLKOUT) begin
            next_clk_ctrl = i_wdata & `CLK_MASK;
        end
    end

    // Read data registered; force register always reads zero
    always_comb begin
        next_rdata = rdata;
        if (i_rd) begin
            if (i_sel == `SEL_CAUSE) begin
                next_rdata = cause;
            end else if (i_sel == `SEL_OPTIONS) begin
                next_rdata = options & `OPT_MASK;
            end else if (i_sel == `SEL_CLKOUT) begin
                next_rdata = clk_ctrl;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end
    assign o_rdata = rdata;

    assign o_watchdog_enable = options[`OPT_WD_ENABLE];
    assign o_watchdog_period_select = options[`OPT_WD_PERIOD];
    assign o_watchdog_log2_period = options[`OPT_WD_PERIOD] ? 5'(`WD_LONG_LOG2) : 5'(`WD_SHORT_LOG2);
    assign o_stop_mode_enable = options[`OPT_STOP_ENABLE];

    clock_out_divider #(
        .DIV_W(3)
    ) u_div (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_enable(clk_ctrl[`CLK_ENABLE]),
        .i_divide(clk_ctrl[`CLK_DIV_HI:0]),
        .o_level(clk_level)
    );

    assign o_shared_port_pin_out = clk_ctrl[`CLK_ENABLE] ? clk_level : i_port_data;
    assign o_shared_port_pin_oen = !(clk_ctrl[`CLK_ENABLE] || i_port_dir);
endmodule : system_reset_config_regs
`default_nettype wire

// file: test/debug_host_model.sv
// Debug host model issuing background writes to the force-reset register
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
    input wire logic i_clk,
    output logic o_wr,
    output logic o_debug_access,
    output logic [7:0] o_wdata
);
    // Idle with no write pending
    initial begin
        o_wr = 1'b0;
        o_debug_access = 1'b0;
        o_wdata = 8'h00;
    end
    // debug write path
    // Data is inverted after release so a stale value never reads as valid
    task automatic send(input logic [7:0] v);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_debug_access <= 1'b1;
        o_wdata <= v;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_debug_access <= 1'b0;
        o_wdata <= ~v;
    endtask : send
endmodule : debug_host_model
`default_nettype wire

// file: test/system_reset_config_regs_asserts.sv
// Port checks for the system reset and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module system_reset_config_regs_asserts (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_pin_reset_req,
    input wire logic i_watchdog_timeout,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_debug_access,
    input wire logic [1:0] i_sel,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_reset_req,
    input wire logic o_watchdog_restart,
    input wire logic o_watchdog_enable,
    input wire logic o_watchdog_period_select,
    input wire logic o_stop_mode_enable,
    input wire logic [4:0] o_watchdog_log2_period
);
    // One clock domain, checks paused in reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_debug_force; i_wr && i_debug_access && i_sel == 2'h1 && i_wdata[0]; endsequence
    property p_restart; i_wr && i_sel == 2'h0 |-> o_watchdog_restart; endproperty
    a_restart: assert property (p_restart) else $error("no watchdog restart");
    property p_period; o_watchdog_log2_period == (o_watchdog_period_select ? 5'h12 : 5'h0d); endproperty
    a_period: assert property (p_period) else $error("bad watchdog period");
    property p_opt_reset;
        $rose(i_rstn) |-> o_watchdog_enable && o_watchdog_period_select && !o_stop_mode_enable;
    endproperty
    a_opt_reset: assert property (p_opt_reset) else $error("bad option defaults");
    property p_force_read; i_rd && i_sel == 2'h1 |=> o_rdata == 8'h00; endproperty
    a_force_read: assert property (p_force_read) else $error("force register read nonzero");
    property p_opt_zero; i_rd && i_sel == 2'h2 |=> o_rdata[3:2] == 2'h0; endproperty
    a_opt_zero: assert property (p_opt_zero) else $error("option spare bits set");
    property p_force_pulse; s_debug_force |=> o_reset_req; endproperty
    a_force_pulse: assert property (p_force_pulse) else $error("no forced reset");
    property p_pin; i_pin_reset_req |-> o_reset_req; endproperty
    a_pin: assert property (p_pin) else $error("pin reset lost");
    property p_wd; i_watchdog_timeout && o_watchdog_enable |-> o_reset_req; endproperty
    a_wd: assert property (p_wd) else $error("watchdog reset lost");
endmodule : system_reset_config_regs_asserts
`default_nettype wire

// file: test/system_reset_config_regs_tb_top.sv
// Bench for the system reset and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module system_reset_config_regs_tb_top;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [7:0] src = 8'h00;
    logic bwr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] bsel = 2'h0;
    logic [7:0] bwd = 8'h00;
    logic lvse = 1'b1;
    logic bme = 1'b0;
    logic pdir = 1'b0;
    logic hwr, hacc, req, wrst, wden, per, stopen, pin, oen;
    logic [7:0] hwd, rdata, got;
    logic [4:0] log2p;
    int err_count = 0;
    int checks = 0;
    int idx [9] = '{0, 1, 2, 1, 5, 4, 3, 6, 7};
    logic [7:0] cause_exp [9] = '{8'h82, 8'h82, 8'h40, 8'h02, 8'h04, 8'h10, 8'h20, 8'h10, 8'h10};
    // Bus clock at 40 MHz
    always #12.5 i_clk = ~i_clk;
    debug_host_model i_host (.i_clk(i_clk), .o_wr(hwr), .o_debug_access(hacc), .o_wdata(hwd));
    // Debug host wins the shared write path while it writes
    system_reset_config_regs i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_power_on_req(src[0]),
        .i_low_volt_trip(src[1]), .i_pin_reset_req(src[2]), .i_watchdog_timeout(src[3]),
        .i_illegal_opcode(src[4]), .i_clock_gen_req(src[5]), .i_stop_exec(src[6]), .i_background_exec(src[7]),
        .i_background_mode_enable(bme), .i_low_voltage_reset_enable(1'b1), .i_low_voltage_stop_enable(lvse),
        .i_wr(bwr | hwr), .i_rd(i_rd), .i_debug_access(hacc), .i_sel(hwr ? 2'h1 : bsel),
        .i_wdata(hwr ? hwd : bwd), .i_port_dir(pdir), .i_port_data(1'b1), .o_rdata(rdata),
        .o_reset_req(req), .o_watchdog_restart(wrst), .o_watchdog_enable(wden), .o_watchdog_period_select(per),
        .o_stop_mode_enable(stopen), .o_watchdog_log2_period(log2p), .o_shared_port_pin_out(pin),
        .o_shared_port_pin_oen(oen));
    task automatic conclude();
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(posedge i_clk);
        bwr <= 1'b1;
        bsel <= s;
        bwd <= d;
        @(posedge i_clk);
        bwr <= 1'b0;
        bwd <= ~d;
    endtask : wr
    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        bsel <= s;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd
    // One-cycle pulse on a reset source, then time to settle
    task automatic hit(input int b);
        @(posedge i_clk);
        src[b] <= 1'b1;
        @(posedge i_clk);
        src[b] <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask : hit
    // Cycles between two pin changes; bounded so a dead pin cannot hang
    task automatic half(output logic [7:0] n);
        logic l;
        int k;
        n = 8'h00;
        k = 0;
        for (int p = 0; p < 2; p++) begin
            l = pin;
            n = 8'h00;
            while (pin === l && k < 40) begin
                @(posedge i_clk);
                #1 k++;
                n++;
            end
        end
        if (k >= 40) begin
            err_count++;
            conclude();
        end
    endtask : half
    initial begin
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd(2'h2, 8'hc0);
        chk({wden, per, stopen, log2p}, 8'hd2);
        rd(2'h1, 8'h00);
        for (int i = 0; i < 9; i++) begin
            hit(idx[i]);
            rd(2'h0, cause_exp[i]);
        end
        wr(2'h0, 8'hff);
        rd(2'h0, 8'h10);
        i_host.send(8'h00);
        rd(2'h0, 8'h10);
        i_host.send(8'h01);
        repeat (3) @(posedge i_clk);
        rd(2'h0, 8'h00);
        // Gated sources must not reset: flags stay clear
        @(posedge i_clk);
        lvse <= 1'b0;
        bme <= 1'b1;
        hit(1);
        hit(7);
        rd(2'h0, 8'h00);
        wr(2'h2, 8'h2c);
        rd(2'h2, 8'h20);
        chk({wden, per, stopen, log2p}, 8'h2d);
        wr(2'h2, 8'hff);
        rd(2'h2, 8'h20);
        wr(2'h1, 8'h01);
        repeat (3) @(posedge i_clk);
        rd(2'h2, 8'h20);
        hit(3);
        rd(2'h2, 8'h20);
        wr(2'h3, 8'h12);
        rd(2'h3, 8'h12);
        chk({7'h00, oen}, 8'h00);
        half(got);
        chk(got, 8'h02);
        wr(2'h3, 8'h10);
        repeat (3) @(posedge i_clk);
        #1 chk({6'h00, oen, pin}, 8'h00);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h17);
        wr(2'h3, 8'h00);
        repeat (2) @(posedge i_clk);
        #1 chk({6'h00, oen, pin}, 8'h03);
        // Clock output off: port direction owns the pin again
        @(posedge i_clk);
        pdir <= 1'b1;
        @(posedge i_clk);
        #1 chk({6'h00, oen, pin}, 8'h01);
        conclude();
    end
endmodule : system_reset_config_regs_tb_top
bind system_reset_config_regs system_reset_config_regs_asserts i_chk (.*);
`default_nettype wire
